// File: logic/plr_pkg.sv
/*
 * Shared constants and types for the front panel lockout and reset supervisor.
 * Assumes a single 50 MHz system clock and buttons already debounced and
 * synchronous to that clock.
 */
package plr_pkg;
    // Clock rate and cycle count of one millisecond.
    localparam int unsigned CLK_HZ   = 50000000;
    localparam int unsigned MS_CYC   = CLK_HZ / 1000;
    localparam int unsigned CNT_W    = 28;
    // Panel geometry: button indices, listed in clockwise order.
    localparam int unsigned BTN_N    = 6;
    localparam int unsigned BTN_ON   = 0;
    localparam int unsigned BTN_OFF  = 1;
    // Times in milliseconds.
    localparam int unsigned HOLD_MS  = 3000;
    localparam int unsigned WIN_MS   = 1000;
    localparam int unsigned FAST_MS  = 100;
    localparam int unsigned SLOW_MS  = 400;
    localparam int unsigned BLINK_MS = 200;
    localparam int unsigned SCRL_MS  = 150;
    // Times in clock cycles.
    localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'(HOLD_MS * MS_CYC);
    localparam logic [CNT_W-1:0] WIN_CYC   = CNT_W'(WIN_MS * MS_CYC);
    localparam logic [CNT_W-1:0] FAST_CYC  = CNT_W'(FAST_MS * MS_CYC);
    localparam logic [CNT_W-1:0] SLOW_CYC  = CNT_W'(SLOW_MS * MS_CYC);
    localparam logic [CNT_W-1:0] BLINK_CYC = CNT_W'(BLINK_MS * MS_CYC);
    localparam logic [CNT_W-1:0] SCRL_CYC  = CNT_W'(SCRL_MS * MS_CYC);
    // Blink counts of the acknowledgement patterns.
    localparam logic [2:0] PANEL_BLINKS = 3'h3;
    localparam logic [2:0] ARM_BLINKS   = 3'h1;
    localparam logic [2:0] DONE_BLINKS  = 3'h4;
    // Reset-button sequencer states.
    typedef enum logic [8:0] {
        RS_BOOT   = 9'h001,
        RS_IDLE   = 9'h002,
        RS_HOLD   = 9'h004,
        RS_ARMED  = 9'h008,
        RS_WIN    = 9'h010,
        RS_PRESS2 = 9'h020,
        RS_CFG    = 9'h040,
        RS_FW     = 9'h080,
        RS_SCROLL = 9'h100
    } plr_rstate_t;
    // One byte of configuration or firmware data from a host port.
    typedef struct packed {
        logic       valid;
        logic       is_fw;
        logic [7:0] data;
    } plr_cfg_t;
    // Indicator outputs of the panel.
    typedef struct packed {
        logic [BTN_N-1:0] btn;
        logic             act_red;
        logic             act_green;
        logic             reset;
    } plr_leds_t;
endpackage : plr_pkg

// File: logic/plr_panel_supervisor.sv
/*
 * Front panel supervisor: lockout gesture and host lock control, lockout
 * acknowledgement flashes, reset-button sequences and host data port merge.
 * Assumes debounced, clock-synchronous button levels and a restore engine
 * elsewhere that reports completion with one-cycle pulses.
 */
`timescale 1ns/100ps

// Counts out a number of on/off blinks of a given half period.
module plr_blinker (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       start,
    input  wire logic [2:0]                 blinks,
    input  wire logic [plr_pkg::CNT_W-1:0]  half,
    output logic                            active,
    output logic                            lit
);
    import plr_pkg::*;
    logic [3:0]       phases;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    wire              phase_end = (cnt == period - CNT_W'(1));

    // Each blink is an on phase followed by an off phase.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phases <= 4'h0;
            cnt    <= '0;
            period <= '0;
        end else if (start) begin
            phases <= {blinks, 1'b0};
            cnt    <= '0;
            period <= half;
        end else if (phases != 4'h0) begin
            cnt    <= phase_end ? '0 : cnt + CNT_W'(1);
            phases <= phase_end ? phases - 4'h1 : phases;
        end
    end

    assign active = (phases != 4'h0);
    assign lit    = phases[0] == 1'b0 && active;
endmodule : plr_blinker

module plr_panel_supervisor #(
    parameter logic [plr_pkg::CNT_W-1:0] HOLD_CYC  = plr_pkg::HOLD_CYC,
    parameter logic [plr_pkg::CNT_W-1:0] WIN_CYC   = plr_pkg::WIN_CYC,
    parameter logic [plr_pkg::CNT_W-1:0] FAST_CYC  = plr_pkg::FAST_CYC,
    parameter logic [plr_pkg::CNT_W-1:0] SLOW_CYC  = plr_pkg::SLOW_CYC,
    parameter logic [plr_pkg::CNT_W-1:0] BLINK_CYC = plr_pkg::BLINK_CYC,
    parameter logic [plr_pkg::CNT_W-1:0] SCRL_CYC  = plr_pkg::SCRL_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic [plr_pkg::BTN_N-1:0]  btn_press,
    input  wire logic                       reset_btn,
    input  wire logic                       host_lock_set,
    input  wire logic                       host_lock_clear,
    input  wire logic                       restore_done,
    input  wire logic                       fw_done,
    input  wire plr_pkg::plr_cfg_t          usb_in,
    input  wire plr_pkg::plr_cfg_t          ser_in,
    input  wire logic                       upd_ready,
    output logic                            usb_ready,
    output logic                            ser_ready,
    output plr_pkg::plr_cfg_t               upd_out,
    output logic [plr_pkg::BTN_N-1:0]       press_evt,
    output logic                            locked,
    output logic                            cfg_restore,
    output logic                            fw_restore,
    output logic                            normal_run,
    output plr_pkg::plr_leds_t              leds
);
    import plr_pkg::*;

    logic             rst_s1;
    logic             rst_sn;
    logic [BTN_N-1:0] press_q;
    logic [CNT_W-1:0] hold_cnt;
    logic             hold_done;
    logic [1:0]       act_sel;
    logic             pb_active;
    logic             pb_lit;
    logic             rb_active;
    logic             rb_lit;
    plr_rstate_t      rstate;
    plr_rstate_t      next_rstate;
    logic [CNT_W-1:0] rcnt;
    logic [CNT_W-1:0] scnt;
    logic [BTN_N-1:0] scroll;

    // Reset release passes through two flip-flops.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_sn <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sn <= rst_s1;
        end
    end

    // Gesture and press decoding.
    wire [BTN_N-1:0] rise     = btn_press & ~press_q;
    wire             both     = btn_press[BTN_ON] & btn_press[BTN_OFF];
    wire             gesture  = both && !hold_done && hold_cnt == HOLD_CYC - CNT_W'(1);
    wire             lock_hit = locked && (rise != '0);
    wire             next_locked = host_lock_set   ? 1'b1 :
                                   host_lock_clear ? 1'b0 :
                                   gesture         ? ~locked : locked;
    wire             pb_start = gesture || lock_hit;
    wire [CNT_W-1:0] pb_half  = (gesture && locked) ? SLOW_CYC : FAST_CYC;

    // Lock state, press events and the two-button hold timer.
    always_ff @(posedge clock or negedge rst_sn) begin
        if (!rst_sn) begin
            press_q   <= '0;
            press_evt <= '0;
            locked    <= 1'b0;
            hold_cnt  <= '0;
            hold_done <= 1'b0;
        end else begin
            press_q   <= btn_press;
            press_evt <= locked ? '0 : rise;
            locked    <= next_locked;
            hold_cnt  <= (both && !hold_done && !gesture) ?
                         hold_cnt + CNT_W'(1) : '0;
            hold_done <= both && (hold_done || gesture);
        end
    end

    // Activity LED colour follows the flash that was started last.
    always_ff @(posedge clock or negedge rst_sn) begin
        if (!rst_sn) begin
            act_sel <= 2'h0;
        end else if (pb_start) begin
            act_sel <= !gesture ? 2'h0 : (locked ? 2'h2 : 2'h1);
        end
    end

    plr_blinker u_panel_blink (
        .clock  (clock),
        .rst_n  (rst_sn),
        .start  (pb_start),
        .blinks (PANEL_BLINKS),
        .half   (pb_half),
        .active (pb_active),
        .lit    (pb_lit)
    );

    // Reset-button sequencer transitions.
    wire hold_up = rcnt == HOLD_CYC - CNT_W'(1);
    wire win_up  = rcnt == WIN_CYC - CNT_W'(1);
    always_comb begin
        next_rstate = rstate;
        case (rstate)
            RS_BOOT:   next_rstate = reset_btn ? RS_FW : RS_IDLE;
            RS_IDLE:   next_rstate = reset_btn ? RS_HOLD : RS_IDLE;
            RS_HOLD:   next_rstate = !reset_btn ? RS_IDLE :
                                     hold_up ? RS_ARMED : RS_HOLD;
            RS_ARMED:  next_rstate = reset_btn ? RS_ARMED : RS_WIN;
            RS_WIN:    next_rstate = reset_btn ? RS_PRESS2 :
                                     win_up ? RS_IDLE : RS_WIN;
            RS_PRESS2: next_rstate = reset_btn ? RS_PRESS2 : RS_CFG;
            RS_CFG:    next_rstate = restore_done ? RS_IDLE : RS_CFG;
            RS_FW:     next_rstate = fw_done ? RS_SCROLL : RS_FW;
            RS_SCROLL: next_rstate = reset_btn ? RS_SCROLL : RS_IDLE;
            default:   next_rstate = RS_IDLE;
        endcase
    end

    // Sequencer state, its timer and the restore requests.
    always_ff @(posedge clock or negedge rst_sn) begin
        if (!rst_sn) begin
            rstate      <= RS_BOOT;
            rcnt        <= '0;
            cfg_restore <= 1'b0;
            fw_restore  <= 1'b0;
            normal_run  <= 1'b0;
        end else begin
            rstate      <= next_rstate;
            rcnt        <= (next_rstate == rstate) ? rcnt + CNT_W'(1) : '0;
            cfg_restore <= rstate == RS_PRESS2 && !reset_btn;
            fw_restore  <= rstate == RS_BOOT && reset_btn;
            normal_run  <= normal_run || next_rstate == RS_IDLE;
        end
    end

    wire rb_start = (rstate == RS_HOLD && reset_btn && hold_up) ||
                    (rstate == RS_CFG && restore_done);
    plr_blinker u_reset_blink (
        .clock  (clock),
        .rst_n  (rst_sn),
        .start  (rb_start),
        .blinks (rstate == RS_CFG ? DONE_BLINKS : ARM_BLINKS),
        .half   (BLINK_CYC),
        .active (rb_active),
        .lit    (rb_lit)
    );

    // Clockwise chase of the button lights after a firmware restore.
    always_ff @(posedge clock or negedge rst_sn) begin
        if (!rst_sn) begin
            scnt   <= '0;
            scroll <= BTN_N'(1);
        end else if (rstate == RS_SCROLL) begin
            scnt   <= (scnt == SCRL_CYC - CNT_W'(1)) ? '0 : scnt + CNT_W'(1);
            scroll <= (scnt == SCRL_CYC - CNT_W'(1)) ?
                      {scroll[BTN_N-2:0], scroll[BTN_N-1]} : scroll;
        end
    end

    // Indicator drive. A fresh hold of the reset button shows steady light even
    // while the tail of an earlier done blink is still running.
    wire held_led = (rstate == RS_HOLD || rstate == RS_ARMED) && reset_btn;
    assign leds.btn       = (rstate == RS_SCROLL) ? scroll : {BTN_N{pb_lit}};
    assign leds.act_red   = act_sel == 2'h1 && pb_lit;
    assign leds.act_green = act_sel == 2'h2 && pb_lit;
    assign leds.reset     = (rb_active && rstate != RS_HOLD) ? rb_lit : held_led;

    // Host data merge: USB first, serial when USB is idle.
    wire take = !upd_out.valid || upd_ready;
    assign usb_ready = take;
    assign ser_ready = take && !usb_in.valid;
    always_ff @(posedge clock or negedge rst_sn) begin
        if (!rst_sn) begin
            upd_out <= '0;
        end else if (take) begin
            upd_out <= usb_in.valid ? usb_in : ser_in;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sn);

    sequence s_gesture_unlocked;
        gesture && !locked && !host_lock_set && !host_lock_clear;
    endsequence
    sequence s_gesture_locked;
        gesture && locked && !host_lock_set && !host_lock_clear;
    endsequence

    lock_ignores_press_a: assert property (locked |=> press_evt == '0)
        else $error("Press event issued while locked.");
    locked_press_flash_a: assert property (lock_hit |=> pb_active && pb_lit)
        else $error("Locked press did not flash.");
    lock_gesture_a: assert property (s_gesture_unlocked |=> locked)
        else $error("Hold gesture failed to lock.");
    lock_entry_flash_a: assert property (
        s_gesture_unlocked |=> leds.act_red && leds.btn != '0)
        else $error("Lock entry flash missing.");
    unlock_gesture_a: assert property (s_gesture_locked |=> !locked)
        else $error("Hold gesture failed to unlock.");
    unlock_flash_a: assert property (
        s_gesture_locked |=> leds.act_green ##1 leds.act_green)
        else $error("Unlock green flash missing.");
    host_lock_a: assert property (host_lock_set |=> locked)
        else $error("Host lock command ignored.");
    reset_hold_led_a: assert property (rstate == RS_HOLD && reset_btn |-> leds.reset)
        else $error("Reset LED dark while held.");
    arm_blink_a: assert property (
        rstate == RS_HOLD && reset_btn && hold_up |=> rstate == RS_ARMED && rb_active)
        else $error("Arming blink missing.");
    repress_restore_a: assert property (
        rstate == RS_PRESS2 && !reset_btn |=> cfg_restore ##1 !cfg_restore)
        else $error("Config restore pulse wrong.");
    done_blinks_a: assert property (
        rstate == RS_CFG && restore_done |=> rb_active && rstate == RS_IDLE)
        else $error("Restore done blinks missing.");
    fw_strap_a: assert property (
        rstate == RS_BOOT && reset_btn |=> fw_restore && !normal_run)
        else $error("Firmware restore not requested.");
    fw_scroll_a: assert property (
        rstate == RS_FW && fw_done |=> rstate == RS_SCROLL && leds.btn == BTN_N'(1))
        else $error("Scroll did not start.");
    usb_accept_a: assert property (
        usb_in.valid && usb_ready |=> upd_out == $past(usb_in))
        else $error("USB data not taken.");
    window_timeout_a: assert property (
        rstate == RS_WIN && !reset_btn && win_up |=> rstate == RS_IDLE ##1 !cfg_restore)
        else $error("Window timeout mishandled.");
    early_release_a: assert property (hold_cnt != '0 && !both |=> hold_cnt == '0)
        else $error("Hold timer not cancelled.");

    // Lock and config restore change only in their own sequences, a normal boot skips fw restore, scroll lamps are one-hot, and serial yields to USB.
    lock_steady_a: assert property (
        !both && !host_lock_set && !host_lock_clear |=> locked == $past(locked))
        else $error("Lock changed without a command.");
    cfg_in_sequence_a: assert property (
        cfg_restore |-> rstate == RS_CFG)
        else $error("Config restore outside its sequence.");
    boot_normal_a: assert property (
        rstate == RS_BOOT && !reset_btn |=> rstate == RS_IDLE && !fw_restore && normal_run)
        else $error("Normal start mishandled.");
    serial_yield_a: assert property (
        usb_in.valid |-> !ser_ready)
        else $error("Serial byte taken over a USB byte.");
    scroll_onehot_a: assert property (
        rstate == RS_SCROLL |-> $onehot(leds.btn))
        else $error("Scroll lamps not lit one at a time.");
endmodule : plr_panel_supervisor

// File: verif/plr_operator.sv
/*
 * Operator model: a person pressing the panel buttons and the reset button.
 * Assumes the bench asks for each gesture with a one-cycle go pulse.
 */
`timescale 1ns/100ps

module plr_operator (
    input  wire logic                      clock,
    input  wire logic                      go,
    input  wire logic [plr_pkg::BTN_N-1:0] mask,
    input  wire logic                      rb,
    input  wire logic [15:0]               len,
    output logic      [plr_pkg::BTN_N-1:0] btn_press,
    output logic                           reset_btn
);
    import plr_pkg::*;
    logic [15:0] cnt;

    // A person starts with hands off the panel.
    initial begin
        btn_press = '0;
        reset_btn = 1'b0;
        cnt       = 16'h0000;
    end

    // Holds the gesture for len cycles, or until the next request when len is zero.
    always @(posedge clock) begin
        if (go) begin
            btn_press <= mask;
            reset_btn <= rb;
            cnt       <= len;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
            if (cnt == 16'h0001) begin
                btn_press <= '0;
                reset_btn <= 1'b0;
            end
        end
    end
endmodule : plr_operator

// File: verif/plr_panel_supervisor_tb.sv
/*
 * Self-checking bench for the panel supervisor with shortened timings.
 * Assumes the operator model drives the buttons and the bench plays the host.
 */
`timescale 1ns/100ps

module plr_panel_supervisor_tb;
    import plr_pkg::*;
    localparam int H = 40, W = 20, F = 4, S = 8, B = 4, R = 3;
    logic             clock, rst_n, go, rb, hs, hc, rdone, fdone, upd_ready, ur_rand;
    logic             reset_btn, usb_ready, ser_ready, locked, cfg_restore, fw_restore;
    logic             normal_run;
    logic [BTN_N-1:0] mask, btn_press, press_evt, evt_or;
    logic [15:0]      len;
    plr_cfg_t         usb_in, ser_in, upd_out;
    plr_leds_t        leds;
    logic [1:0]       hv [4] = '{2'b10, 2'b01, 2'b11, 2'b01};
    int               miscompares, comparisons, cyc, cfg_n, fw_n, evt_n, idx, n0;
    int               ups [5], hi [5];

    plr_operator u_plr_operator (.clock(clock), .go(go), .mask(mask), .rb(rb), .len(len),
        .btn_press(btn_press), .reset_btn(reset_btn));
    plr_panel_supervisor #(.HOLD_CYC(CNT_W'(H)), .WIN_CYC(CNT_W'(W)), .FAST_CYC(CNT_W'(F)),
        .SLOW_CYC(CNT_W'(S)), .BLINK_CYC(CNT_W'(B)), .SCRL_CYC(CNT_W'(R)))
    u_plr_panel_supervisor (.clock(clock), .rst_n(rst_n), .btn_press(btn_press),
        .reset_btn(reset_btn), .host_lock_set(hs), .host_lock_clear(hc),
        .restore_done(rdone), .fw_done(fdone), .usb_in(usb_in), .ser_in(ser_in),
        .upd_ready(upd_ready), .usb_ready(usb_ready), .ser_ready(ser_ready),
        .upd_out(upd_out), .press_evt(press_evt), .locked(locked),
        .cfg_restore(cfg_restore), .fw_restore(fw_restore), .normal_run(normal_run),
        .leds(leds));

    // Free-running 50 MHz clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Counts pulses, stalls the output side at random and cuts a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cfg_restore) cfg_n <= cfg_n + 1;
        if (fw_restore) fw_n <= fw_n + 1;
        if (|press_evt) begin
            evt_n  <= evt_n + 1;
            evt_or <= evt_or | press_evt;
        end
        if (ur_rand) upd_ready <= 1'($urandom);
        if (cyc == 6000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic op(input logic [BTN_N-1:0] m, input logic r, input int n);
        @(posedge clock);
        mask <= m;
        rb   <= r;
        len  <= 16'(n);
        go   <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        tick(n + 1);
    endtask : op

    function automatic logic pick(input int sel);
        case (sel)
            0: return leds.act_red;
            1: return leds.act_green;
            2: return leds.btn[0];
            3: return leds.reset;
            default: return !leds.reset;
        endcase
    endfunction : pick

    // Counts rising edges and high cycles of four watched lamps and of the inverted reset lamp over n cycles.
    task automatic watch(input int n);
        logic [4:0] p;
        logic       v;
        p   = '0;
        ups = '{default: 0};
        hi  = '{default: 0};
        repeat (n) begin
            tick(1);
            for (int i = 0; i < 5; i++) begin
                v = pick(i);
                ups[i] += int'(v && !p[i]);
                hi[i] += int'(v);
                p[i] = v;
            end
        end
    endtask : watch

    task automatic send(input logic ser, input logic [8:0] d);
        logic r;
        r = 1'b0;
        @(posedge clock);
        if (ser) ser_in <= {1'b1, d};
        else usb_in <= {1'b1, d};
        for (int k = 0; k < 60 && !r; k++) begin
            @(negedge clock);
            r = ser ? ser_ready : usb_ready;
            @(posedge clock);
        end
        ser_in.valid <= 1'b0;
        usb_in.valid <= 1'b0;
        #1;
        chk("taken", 32'(r), 32'h1);
        chk("upd_out", 32'(upd_out), 32'({1'b1, d}));
    endtask : send

    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence: power-up with reset held, then lockout, reset button and data.
    initial begin
        void'($urandom(30));
        rst_n = 1'b0; hs = 1'b0; hc = 1'b0; rdone = 1'b0; fdone = 1'b0;
        upd_ready = 1'b0; ur_rand = 1'b0; usb_in = '0; ser_in = '0; evt_or = '0;
        mask = '0; rb = 1'b1; len = 16'h0000; go = 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        go    <= 1'b0;
        tick(6);
        chk("fw_restore", 32'(fw_n), 32'h1);
        chk("normal_run", 32'(normal_run), 32'h0);
        @(posedge clock) fdone <= 1'b1;
        @(posedge clock) fdone <= 1'b0;
        for (int k = 0; k < 20 && leds.btn !== 6'h01; k++) tick(1);
        for (int i = 1; i <= 7; i++) begin
            tick(R);
            chk("scroll", 32'(leds.btn), 32'(6'h01 << (i % 6)));
        end
        op('0, 1'b0, 0);
        tick(3);
        chk("normal_run", 32'(normal_run), 32'h1);
        idx = 2 + int'($urandom % 4);
        op(BTN_N'(1) << idx, 1'b0, 3);
        tick(2);
        chk("press_evt", 32'(evt_or), 32'(BTN_N'(1) << idx));
        op(6'h03, 1'b0, H - 1);
        tick(3);
        chk("early", 32'(locked), 32'h0);
        // The watch runs beside the gesture so that the flash is seen from its start.
        fork
            op(6'h03, 1'b0, H);
            watch(70);
        join
        chk("locked", 32'(locked), 32'h1);
        chk("red", 32'(ups[0] * 100 + hi[0]), 32'(300 + 3 * F));
        chk("lock btn", 32'(ups[2]), 32'h3);
        n0 = evt_n;
        fork
            op(BTN_N'(1) << (2 + int'($urandom % 4)), 1'b0, 2);
            watch(40);
        join
        chk("ignored", 32'(evt_n - n0), 32'h0);
        chk("flash", 32'(ups[2] * 100 + hi[2]), 32'(300 + 3 * F));
        // Pressing On and Off while locked flashes fast first; that flash is over
        // before the watch starts, and the slow unlock flash is seen whole.
        fork
            op(6'h03, 1'b0, H);
            begin
                tick(30);
                watch(60);
            end
        join
        chk("unlocked", 32'(locked), 32'h0);
        chk("green", 32'(ups[1] * 100 + hi[1]), 32'(300 + 3 * S));
        chk("slow btn", 32'(ups[2] * 100 + hi[2]), 32'(300 + 3 * S));
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            hs <= hv[i][1];
            hc <= hv[i][0];
            @(posedge clock);
            hs <= 1'b0;
            hc <= 1'b0;
            tick(2);
            chk("host lock", 32'(locked), 32'(hv[i][1]));
        end
        op('0, 1'b1, 0);
        tick(2);
        chk("reset led", 32'(leds.reset), 32'h1);
        watch(H + 2 * B + 4);
        chk("arm blink", 32'(ups[4] * 100 + hi[4]), 32'(100 + B));
        chk("reset led", 32'(leds.reset), 32'h1);
        n0 = cfg_n;
        op('0, 1'b0, 0);
        tick(W / 2);
        op('0, 1'b1, 2);
        tick(3);
        chk("cfg_restore", 32'(cfg_n - n0), 32'h1);
        @(posedge clock) rdone <= 1'b1;
        @(posedge clock) rdone <= 1'b0;
        watch(40);
        chk("done blinks", 32'(ups[3]), 32'h4);
        n0 = cfg_n;
        op('0, 1'b1, 0);
        tick(H + 2 * B + 4);
        op('0, 1'b0, 0);
        tick(W + 5);
        op('0, 1'b1, 2);
        tick(5);
        chk("abandon", 32'(cfg_n - n0), 32'h0);
        send(1'b0, 9'h1A5);
        tick(3);
        chk("stands", 32'(upd_out), 32'h3A5);
        chk("stall", 32'({usb_ready, ser_ready}), 32'h0);
        ur_rand = 1'b1;
        for (int i = 0; i < 8; i++) send(i[0], 9'($urandom));
        // A second power-up with the reset button released starts normally.
        n0 = fw_n;
        @(posedge clock) rst_n <= 1'b0;
        tick(2);
        chk("run in reset", 32'(normal_run), 32'h0);
        @(posedge clock) rst_n <= 1'b1;
        tick(5);
        chk("normal boot", 32'(normal_run), 32'h1);
        chk("no fw restore", 32'(fw_n - n0), 32'h0);
        tally_and_finish();
    end
endmodule : plr_panel_supervisor_tb
